// [include/shaft_release_pkg.sv]
// Package: constants and carriers for the shaft release control block
package shaft_release_pkg;

   // ==========================================
   // Widths and reset values
   localparam int   POS_W            = 32;
   localparam logic FREE_RESET_VALUE = 1'b0;
   localparam logic FREE_NORMAL      = 1'b0;
   localparam logic FREE_SHAFT_FREE  = 1'b1;

   // ==========================================
   // Command sources of the setting
   typedef enum logic [1:0] {
      SRC_NONE,
      SRC_IMMEDIATE,
      SRC_SEQUENCE,
      SRC_FIELDBUS
   } cmd_src_e;

   // One command port, one per source
   typedef struct packed {
      logic wr;
      logic rd;
      logic val;
   } free_cmd_s;

   // Driver connector outputs
   typedef struct packed {
      logic current_off;
      logic brake_release;
   } drv_out_s;

endpackage

// [hw/free_cmd_arbiter.sv]
// Arbiter that merges setting writes from three command sources
`timescale 1ns/100ps
module free_cmd_arbiter (
   // Command sources
   input  wire shaft_release_pkg::free_cmd_s imm_cmd,
   input  wire shaft_release_pkg::free_cmd_s seq_cmd,
   input  wire shaft_release_pkg::free_cmd_s bus_cmd,
   // Merged write
   output logic                              wr,
   output logic                              val,
   output shaft_release_pkg::cmd_src_e       src
);

   // ==========================================
   // Fixed priority: immediate over sequence over fieldbus
   always_comb begin
      wr  = 1'b0;
      val = shaft_release_pkg::FREE_NORMAL;
      src = shaft_release_pkg::SRC_NONE;
      if (imm_cmd.wr) begin
         wr  = 1'b1;
         val = imm_cmd.val;
         src = shaft_release_pkg::SRC_IMMEDIATE;
      end else if (seq_cmd.wr) begin
         wr  = 1'b1;
         val = seq_cmd.val;
         src = shaft_release_pkg::SRC_SEQUENCE;
      end else if (bus_cmd.wr) begin
         wr  = 1'b1;
         val = bus_cmd.val;
         src = shaft_release_pkg::SRC_FIELDBUS;
      end
   end

endmodule

// [hw/brake_gate.sv]
// Brake release gating against loss of holding torque
`timescale 1ns/100ps
module brake_gate (
   // Inputs
   input  wire logic release_state,
   input  wire logic current_cutoff,
   input  wire logic alarm,
   // Output
   output logic      brake_release
);

   // ==========================================
   // Brake must close whenever torque is lost
   always_comb begin
      brake_release = release_state & ~current_cutoff & ~alarm;
   end

endmodule

// [hw/motor_shaft_release_control.sv]
// Shaft release control: setting, release sources, driver and brake outputs
`timescale 1ns/100ps

// Operation
// - One-bit release setting, 0 normal, 1 shaft free, reset to 0.
// - Setting read and written by immediate, sequence and fieldbus commands.
// - Release state drives driver current-off, driver brake and I/O brake outputs.
// - Release also asserted by assigned I/O input or fieldbus remote bit.
// - A setting write acts regardless of input or remote bit states.
// - On release becoming 1, position command loads position feedback.
// - Release 1 asserts current-off output to a driver with that input.
// - Release 1 asserts driver brake-release output; current unaffected.
// - Brake release drops on current cutoff or alarm.
// - I/O brake output frees external brake while release is 1.
module motor_shaft_release_control #(
   parameter int POS_W = shaft_release_pkg::POS_W
) (
   // Clock and reset
   input  wire logic                         core_clk,
   input  wire logic                         srst,
   // Command sources
   input  wire shaft_release_pkg::free_cmd_s imm_cmd,
   input  wire shaft_release_pkg::free_cmd_s seq_cmd,
   input  wire shaft_release_pkg::free_cmd_s bus_cmd,
   // Release inputs
   input  wire logic                         release_input,
   input  wire logic                         release_input_assignment,
   input  wire logic                         remote_release_bit,
   // Driver and brake configuration
   input  wire logic                         drv_has_current_off,
   input  wire logic                         drv_has_brake_release,
   input  wire logic                         brake_release_output_assigned,
   // Torque status
   input  wire logic                         current_cutoff,
   input  wire logic                         alarm,
   // Position
   input  wire logic [POS_W-1:0]             position_feedback,
   input  wire logic                         pos_cmd_wr,
   input  wire logic [POS_W-1:0]             pos_cmd_wdata,
   // Readback
   output logic                              free_setting,
   output logic                              release_state,
   output logic                              rd_ack,
   output logic [POS_W-1:0]                  position_command,
   // Driver connector
   output shaft_release_pkg::drv_out_s       drv_out,
   // I/O connector
   output logic                              brake_release_output
);

   // ==========================================
   // State
   logic                          setting_reg;
   logic                          setting_next;
   logic                          state_reg;
   logic                          state_next;
   logic                          rd_ack_reg;
   logic                          rd_ack_next;
   logic [POS_W-1:0]              pos_cmd_reg;
   logic [POS_W-1:0]              pos_cmd_next;
   shaft_release_pkg::drv_out_s   drv_reg;
   shaft_release_pkg::drv_out_s   drv_next;
   logic                          io_brake_reg;
   logic                          io_brake_next;
   logic                          arb_wr;
   logic                          arb_val;
   shaft_release_pkg::cmd_src_e   arb_src;
   logic                          brake_ok;
   logic                          rise;

   // ==========================================
   // Command merge
   free_cmd_arbiter u_arb (
      .imm_cmd (imm_cmd),
      .seq_cmd (seq_cmd),
      .bus_cmd (bus_cmd),
      .wr      (arb_wr),
      .val     (arb_val),
      .src     (arb_src)
   );

   // Brake gating on torque loss
   brake_gate u_gate (
      .release_state  (state_next),
      .current_cutoff (current_cutoff),
      .alarm          (alarm),
      .brake_release  (brake_ok)
   );

   // ==========================================
   // Helpers
   // Mapped I/O pin counts toward release only while assigned
   function automatic logic io_release(input logic pin, input logic assigned);
      return pin & assigned;
   endfunction

   // Holding torque is gone on a current cutoff or an alarm
   function automatic logic torque_lost(input logic cutoff, input logic fault);
      return cutoff | fault;
   endfunction

   // ==========================================
   // Setting group
   // One-bit setting
   always_comb begin
      setting_next = setting_reg;
      if (arb_wr) begin
         setting_next = arb_val;
      end
      // Reads answer on any source; the data is free_setting itself
      rd_ack_next  = imm_cmd.rd | seq_cmd.rd | bus_cmd.rd;
   end

   // Setting registers
   always_ff @(posedge core_clk) begin
      if (srst) begin
         setting_reg <= shaft_release_pkg::FREE_RESET_VALUE;
         rd_ack_reg  <= 1'b0;
      end else begin
         setting_reg <= setting_next;
         rd_ack_reg  <= rd_ack_next;
      end
   end

   // ==========================================
   // Release group
   // I/O input and remote bit
   always_comb begin
      // The write enters through setting_next so it acts in the same cycle
      state_next = setting_next
                 | io_release(release_input, release_input_assignment)
                 | remote_release_bit;
      // Rise seen before the edge so the load lands with the new state
      rise       = state_next & ~state_reg;
   end

   // Release registers
   always_ff @(posedge core_clk) begin
      if (srst) begin
         state_reg <= shaft_release_pkg::FREE_RESET_VALUE;
      end else begin
         state_reg <= state_next;
      end
   end

   // ==========================================
   // Position command group
   // Feedback load on rise
   always_comb begin
      // Load wins over a host write, else a hand-taught position is lost
      if (rise) begin
         pos_cmd_next = position_feedback;
      end else if (pos_cmd_wr) begin
         pos_cmd_next = pos_cmd_wdata;
      end else begin
         pos_cmd_next = pos_cmd_reg;
      end
   end

   // Position command register
   always_ff @(posedge core_clk) begin
      if (srst) begin
         pos_cmd_reg <= '0;
      end else begin
         pos_cmd_reg <= pos_cmd_next;
      end
   end

   // ==========================================
   // Output group
   always_comb begin
      drv_next.current_off   = state_next & drv_has_current_off;
      drv_next.brake_release = brake_ok & drv_has_brake_release;
      io_brake_next          = brake_ok & brake_release_output_assigned;
   end

   // Output registers; current-off is not gated, an alarm already cuts current
   always_ff @(posedge core_clk) begin
      if (srst) begin
         drv_reg      <= '0;
         io_brake_reg <= 1'b0;
      end else begin
         drv_reg      <= drv_next;
         io_brake_reg <= io_brake_next;
      end
   end

   // Outputs straight from flops
   assign free_setting         = setting_reg;
   assign release_state        = state_reg;
   assign rd_ack               = rd_ack_reg;
   assign position_command     = pos_cmd_reg;
   assign drv_out              = drv_reg;
   assign brake_release_output = io_brake_reg;

   // ==========================================
   // Assertions
   a_reset_setting_zero: assert property (@(posedge core_clk)
      srst |=> !setting_reg) else $error("setting not cleared by reset");

   a_write_sets_value: assert property (@(posedge core_clk) disable iff (srst)
      arb_wr |=> setting_reg == $past(arb_val)) else $error("setting write lost");

   a_write_overrides_input: assert property (@(posedge core_clk) disable iff (srst)
      (arb_wr && arb_val) |=> state_reg) else $error("write did not release");

   a_remote_releases: assert property (@(posedge core_clk) disable iff (srst)
      remote_release_bit |=> state_reg) else $error("remote bit ignored");

   a_or_of_sources: assert property (@(posedge core_clk) disable iff (srst)
      1'b1 |=> release_state == (free_setting | io_release($past(release_input), $past(release_input_assignment))
                                 | $past(remote_release_bit))) else $error("release state not OR");

   sequence s_release_rise;
      !state_reg ##1 state_reg;
   endsequence

   a_cmd_loads_feedback: assert property (@(posedge core_clk) disable iff (srst)
      (!state_reg && state_next) |=> position_command == $past(position_feedback))
      else $error("position command not loaded");

   a_current_off_follows: assert property (@(posedge core_clk) disable iff (srst)
      s_release_rise |-> drv_out.current_off == $past(drv_has_current_off))
      else $error("current off wrong");

   a_brake_drops_alarm: assert property (@(posedge core_clk) disable iff (srst)
      (alarm || current_cutoff) |=> !drv_out.brake_release && !brake_release_output)
      else $error("brake released without torque");

   a_io_brake_follows: assert property (@(posedge core_clk) disable iff (srst)
      (state_next && brake_release_output_assigned && !alarm && !current_cutoff) |=> brake_release_output)
      else $error("io brake not released");

   a_drv_brake_follows: assert property (@(posedge core_clk) disable iff (srst)
      (state_next && drv_has_brake_release && !alarm && !current_cutoff) |=> drv_out.brake_release)
      else $error("driver brake not released");

   // ==========================================
   // Source selection and read answer
   a_imm_wins: assert property (@(posedge core_clk) disable iff (srst)
      imm_cmd.wr |-> (arb_src == shaft_release_pkg::SRC_IMMEDIATE) && (arb_val == imm_cmd.val))
      else $error("immediate write not selected");

   a_seq_write_taken: assert property (@(posedge core_clk) disable iff (srst)
      (!imm_cmd.wr && seq_cmd.wr) |=> free_setting == $past(seq_cmd.val))
      else $error("sequence write lost");

   a_bus_write_taken: assert property (@(posedge core_clk) disable iff (srst)
      (!imm_cmd.wr && !seq_cmd.wr && bus_cmd.wr) |=> free_setting == $past(bus_cmd.val))
      else $error("fieldbus write lost");

   a_setting_holds: assert property (@(posedge core_clk) disable iff (srst)
      !arb_wr |=> $stable(free_setting))
      else $error("setting changed without write");

   a_read_acked: assert property (@(posedge core_clk) disable iff (srst)
      (imm_cmd.rd || seq_cmd.rd || bus_cmd.rd) |=> rd_ack)
      else $error("read not answered");

   a_no_stray_ack: assert property (@(posedge core_clk) disable iff (srst)
      !(imm_cmd.rd || seq_cmd.rd || bus_cmd.rd) |=> !rd_ack)
      else $error("answer without read");

   // ==========================================
   // Release sources and outputs
   a_io_input_releases: assert property (@(posedge core_clk) disable iff (srst)
      io_release(release_input, release_input_assignment) |=> release_state)
      else $error("assigned input ignored");

   a_unassigned_ignored: assert property (@(posedge core_clk) disable iff (srst)
      (!release_input_assignment && !setting_next && !remote_release_bit) |=> !release_state)
      else $error("unassigned input released");

   a_clear_returns: assert property (@(posedge core_clk) disable iff (srst)
      (arb_wr && !arb_val && !io_release(release_input, release_input_assignment) && !remote_release_bit)
      |=> !release_state && !free_setting)
      else $error("clear write ignored");

   // Release falls, then every output is already down
   sequence s_release_fall;
      state_reg ##1 !state_reg;
   endsequence

   a_outputs_drop: assert property (@(posedge core_clk) disable iff (srst)
      s_release_fall |-> !drv_out.current_off && !drv_out.brake_release && !brake_release_output)
      else $error("output held after release fell");

   a_current_off_level: assert property (@(posedge core_clk) disable iff (srst)
      1'b1 |=> drv_out.current_off == (release_state && $past(drv_has_current_off)))
      else $error("current off level wrong");

   a_current_off_kept: assert property (@(posedge core_clk) disable iff (srst)
      (state_next && drv_has_current_off && torque_lost(current_cutoff, alarm)) |=> drv_out.current_off)
      else $error("current off dropped on torque loss");

   a_brake_needs_input: assert property (@(posedge core_clk) disable iff (srst)
      !drv_has_brake_release |=> !drv_out.brake_release)
      else $error("driver brake without input");

   a_io_brake_blocked: assert property (@(posedge core_clk) disable iff (srst)
      (!brake_release_output_assigned || torque_lost(current_cutoff, alarm)) |=> !brake_release_output)
      else $error("io brake released when blocked");

   // ==========================================
   // Position command
   a_cmd_written: assert property (@(posedge core_clk) disable iff (srst)
      (!rise && pos_cmd_wr) |=> position_command == $past(pos_cmd_wdata))
      else $error("position command write lost");

   a_cmd_holds: assert property (@(posedge core_clk) disable iff (srst)
      (!rise && !pos_cmd_wr) |=> $stable(position_command))
      else $error("position command drifted");

endmodule

// [tb/drv_model.sv]
// Motor driver model that follows the current-off and brake inputs and reports feedback
`timescale 1ns/100ps
module drv_model #(
   parameter logic BRAKE_INPUT_ENABLED = 1'b1
) (
   // Clock
   input  wire logic                        core_clk,
   // Driver connector
   input  wire shaft_release_pkg::drv_out_s drv_out,
   // Encoder
   output logic [31:0]                      position_feedback
);
   logic brake_free;

   assign brake_free = BRAKE_INPUT_ENABLED & drv_out.brake_release;

   // Shaft creeps under drive, moves faster when pushed by hand while free
   initial position_feedback = 32'h0;
   always @(posedge core_clk) begin
      position_feedback <= position_feedback + ((drv_out.current_off | brake_free) ? 32'h11 : 32'h1);
   end
endmodule

// [tb/motor_shaft_release_control_bench.sv]
// Self-checking bench for the shaft release control block
`timescale 1ns/100ps
module motor_shaft_release_control_bench;
   typedef struct packed {
      logic [1:0]  st;
      logic        rd;
      logic [1:0]  drv;
      logic        io;
      logic [31:0] cmd;
   } exp_s;

   // ==========================================
   // Stimulus and observed signals
   logic                         core_clk = 1'b0;
   logic                         srst     = 1'b1;
   logic [8:0]                   cm       = 9'h000;
   logic [7:0]                   lv       = 8'h00;
   logic                         pos_cmd_wr    = 1'b0;
   logic [31:0]                  pos_cmd_wdata = 32'h0;
   wire shaft_release_pkg::free_cmd_s imm_cmd, seq_cmd, bus_cmd;
   wire logic release_input, release_input_assignment, remote_release_bit;
   wire logic drv_has_current_off, drv_has_brake_release, brake_release_output_assigned;
   wire logic current_cutoff, alarm;
   logic [31:0]                  position_feedback, position_command;
   logic                         free_setting, release_state, rd_ack, brake_release_output;
   shaft_release_pkg::drv_out_s  drv_out;
   int                           fail_count = 0;
   int                           check_count = 0;
   exp_s                         q[$];
   exp_s                         e;
   logic                         se = 1'b0, ef, pe = 1'b0;
   logic [31:0]                  cmd_e = 32'h0;

   assign {imm_cmd, seq_cmd, bus_cmd} = cm;
   assign {release_input, release_input_assignment, remote_release_bit, drv_has_current_off,
           drv_has_brake_release, brake_release_output_assigned, current_cutoff, alarm} = lv;

   motor_shaft_release_control #(.POS_W(32)) u_dut (.core_clk, .srst, .imm_cmd, .seq_cmd, .bus_cmd,
      .release_input, .release_input_assignment, .remote_release_bit, .drv_has_current_off,
      .drv_has_brake_release, .brake_release_output_assigned, .current_cutoff, .alarm,
      .position_feedback, .pos_cmd_wr, .pos_cmd_wdata, .free_setting, .release_state, .rd_ack,
      .position_command, .drv_out, .brake_release_output);

   drv_model u_drv (.core_clk, .drv_out, .position_feedback);

   always #2 core_clk = ~core_clk;

   // ==========================================
   // Compare, verdict
   task check(input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         fail_count++;
         $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task summarize;
      $display("checks=%0d errors=%0d", check_count, fail_count);
      if (fail_count == 0 && check_count > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask

   // One cycle of stimulus; write priority immediate over sequence over fieldbus
   task go(input logic [8:0] c, input logic [7:0] l);
      @(negedge core_clk);
      cm = c;
      lv = l;
      srst = 1'b0;
      pos_cmd_wr = 1'($urandom);
      pos_cmd_wdata = $urandom;
      if (c[8]) se = c[6];
      else if (c[5]) se = c[3];
      else if (c[2]) se = c[0];
      ef = se | (l[7] & l[6]) | l[5];
      // Feedback load wins over a position write on the rising cycle
      if (ef & ~pe) cmd_e = position_feedback;
      else if (pos_cmd_wr) cmd_e = pos_cmd_wdata;
      pe = ef;
      q.push_back({se, ef, c[7] | c[4] | c[1], ef & l[4], ef & l[3] & ~|l[1:0], ef & l[2] & ~|l[1:0], cmd_e});
   endtask

   // Reset for two edges in mid-run; every output reads zero meanwhile, next go releases it
   task reset_pulse;
      @(negedge core_clk);
      srst = 1'b1;
      se = 1'b0;
      pe = 1'b0;
      cmd_e = 32'h0;
      q.push_back('0);
      @(negedge core_clk);
      q.push_back('0);
   endtask

   // Monitor: oldest note against what the outputs show after the edge
   always @(posedge core_clk) begin
      if (q.size() > 0) begin
         #1;
         e = q.pop_front();
         check(32'({free_setting, release_state}), 32'(e.st));
         check(32'(rd_ack), 32'(e.rd));
         check(32'(drv_out), 32'(e.drv));
         check(32'(brake_release_output), 32'(e.io));
         check(position_command, e.cmd);
      end
   end

   // ==========================================
   // Main sequence: defaults, priority and overrides, then random traffic
   initial begin
      void'($urandom(32'h65a071dd));
      repeat (6) @(negedge core_clk);
      srst = 1'b0;
      go(9'h000, 8'h00);
      go(9'h140, 8'hff);
      go(9'h12d, 8'h1c);
      go(9'h02c, 8'h1c);
      go(9'h004, 8'h1d);
      // Mid-run reset while the setting holds release
      go(9'h140, 8'h10);
      reset_pulse;
      go(9'h000, 8'h10);
      repeat (400) go(9'($urandom), ($urandom % 4 == 0) ? 8'($urandom) : lv);
      go(9'h000, lv);
      repeat (3) @(posedge core_clk);
      summarize;
   end

   // Watchdog well past the expected run of some 420 cycles
   initial begin
      #4000;
      fail_count++;
      summarize;
   end
endmodule
